// ===== design/cms_pkg.sv
// cms_pkg: link frame layout, device register map, channel order and timing
// assumes both ends share one 125 MHz clock
package cms_pkg;
   // ----------------------------------------
   // link frame
   // ----------------------------------------
   localparam int FRAME_BITS = 24;
   localparam int ADDR_PHASE = 8;
   localparam int DATA_BITS  = 16;

   // ----------------------------------------
   // device register map
   // ----------------------------------------
   localparam logic [6:0] ADDR_FUNC_CTRL     = 7'h01;
   localparam logic [6:0] ADDR_CTRL2         = 7'h02;
   localparam logic [6:0] ADDR_CTRL3         = 7'h03;
   localparam logic [6:0] ADDR_STATUS        = 7'h04;
   localparam logic [6:0] ADDR_PRIM_CELL1    = 7'h09;
   localparam logic [6:0] ADDR_STACK         = 7'h11;
   localparam logic [6:0] ADDR_SECONDARY_REF = 7'h12;
   localparam logic [6:0] ADDR_REG_CHECK     = 7'h13;
   localparam logic [6:0] ADDR_REF_BUFFER    = 7'h1C;
   localparam logic [6:0] ADDR_REG_REPEAT    = 7'h1D;
   localparam logic [6:0] ADDR_TEMP          = 7'h1E;
   localparam logic [6:0] ADDR_SEC_CELL1     = 7'h29;
   localparam logic [6:0] ADDR_PRIMARY_REF   = 7'h31;
   localparam logic [6:0] ADDR_REG_SEC       = 7'h34;
   localparam int         START_BIT          = 0;
   localparam int         DELAY_BIT          = 6;
   localparam logic [1:0] ACQ_RESET          = 2'h0;
   localparam int         NUM_PRIM           = 18;
   localparam int         NUM_SEC            = 10;
   localparam int         NUM_CELLS          = 8;
   localparam int         MEM_DEPTH          = 64;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS       = 8;
   localparam int ACQ_BASE_NS  = 400;
   localparam int ACQ_BASE_CYC = (ACQ_BASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int START_NS     = 2000;
   localparam int START_CYC    = (START_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_NS      = 1000;
   localparam int CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int DELAY_NS     = 200;
   localparam int DELAY_CYC    = (DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int TEMP_US      = 276;
   localparam int TEMP_CYC     = (TEMP_US * 1000 + CLK_NS - 1) / CLK_NS;

   // ----------------------------------------
   // host register map and check windows (mV)
   // ----------------------------------------
   localparam logic [7:0] HOST_CMD      = 8'h00;
   localparam logic [7:0] HOST_CFG      = 8'h04;
   localparam logic [7:0] HOST_STATUS   = 8'h08;
   localparam logic [7:0] HOST_RES_BASE = 8'h40;
   localparam int FULL_SCALE_MV = 5000;
   localparam int PRIM_BITS     = 14;
   localparam int SEC_BITS      = 10;
   localparam int REF2_MIN = 2485;
   localparam int REF2_MAX = 2515;
   localparam int REG_MIN  = 3200;
   localparam int REG_MAX  = 3421;
   localparam int BUF_MIN  = 2486;
   localparam int BUF_MAX  = 2514;
   localparam int REF1_MIN = 2475;
   localparam int REF1_MAX = 2525;
   localparam int REGS_MIN = 3865;
   localparam int REGS_MAX = 4135;

   typedef enum logic [1:0] {
      OP_CFG   = 2'b00,
      OP_START = 2'b01,
      OP_READ  = 2'b10
   } cms_op_t;

   // primary result index 0..17 to register address
   function automatic logic [6:0] prim_addr(input logic [4:0] idx);
      logic [6:0] a;
      a = ADDR_REF_BUFFER + {2'h0, idx} - 7'h0F;
      if (idx < 5'h08) begin
         a = ADDR_PRIM_CELL1 + {2'h0, idx};
      end else if (idx < 5'h0F) begin
         a = ADDR_STACK + {2'h0, idx} - 7'h08;
      end
      return a;
   endfunction

   // secondary result index 0..9 to register address
   function automatic logic [6:0] sec_addr(input logic [3:0] idx);
      logic [6:0] a;
      a = ADDR_REG_SEC;
      if (idx < 4'h8) begin
         a = ADDR_SEC_CELL1 + {3'h0, idx};
      end else if (idx == 4'h8) begin
         a = ADDR_PRIMARY_REF;
      end
      return a;
   endfunction
endpackage

// ===== design/cms_spi_if.sv
// cms_spi_if: four-wire serial link between host and monitor
// assumes both ends sample the wires on the shared system clock
`timescale 1ns/1ps
interface cms_spi_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;

   modport dev (
      input  sclk,
      input  cs_n,
      input  mosi,
      output miso
   );

   modport host (
      output sclk,
      output cs_n,
      output mosi,
      input  miso
   );
endinterface

// ===== design/cms_dev.sv
// cms_dev: monitor end, link slave, conversion sequencer and result store
// assumes converter codes are valid at the end of each conversion period
`timescale 1ns/1ps

// Functional notes
// - acquisition 400 ns default, two-bit select
// - simultaneous paths unless delay bit set
// - all eight cells converted, unused read zero
// - host reads primary before secondary results
// - eighteen primary results in fixed order
// - host reads all eighteen primary results
// - ten secondary results in fixed order
// - host reads all ten secondary results
// - results travel over four-wire serial link
// - primary check results at fixed addresses
// - secondary check results at fixed addresses
// - host checks internal results against windows
// - start bit launches both paths together
// - dummy slot after start delay
// - cells converted from eight down to one
// - eighteen slots of acquisition plus conversion
// - temperature uses a long extra slot
// - primary straight binary, secondary inverted ten-bit
// - temperature two's complement, zero is 25 C
module cms_dev #(
   parameter int START_CYC = cms_pkg::START_CYC,
   parameter int CONV_CYC  = cms_pkg::CONV_CYC,
   parameter int DELAY_CYC = cms_pkg::DELAY_CYC,
   parameter int TEMP_CYC  = cms_pkg::TEMP_CYC
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   cms_spi_if.dev           spi,
   input  wire logic [3:0]  cells_fitted,
   input  wire logic [13:0] prim_code,
   input  wire logic [9:0]  sec_code,
   input  wire logic [13:0] temp_code,
   output logic      [4:0]  prim_chan,
   output logic             prim_sample,
   output logic      [4:0]  sec_chan,
   output logic             sec_sample,
   output logic             busy
);
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_START = 3'b001,
      S_ACQ   = 3'b010,
      S_CONV  = 3'b011,
      S_TEMP  = 3'b100
   } cms_seq_t;

   localparam logic [4:0] LAST_SLOT = 5'd17;
   localparam logic [4:0] LAST_SEC  = 5'd10;

   cms_seq_t    state_reg;
   logic [15:0] cnt_reg;
   logic [4:0]  slot_reg;
   logic [1:0]  acq_sel_reg;
   logic        delay_en_reg;
   logic        sclk_q;
   logic        cs_q;
   logic [4:0]  bit_cnt_reg;
   logic [23:0] rx_reg;
   logic [15:0] tx_reg;
   logic        miso_reg;
   logic [15:0] mem [0:cms_pkg::MEM_DEPTH-1];

   logic        sclk_rise;
   logic        sclk_fall;
   logic        frame_end;
   logic        wr_frame;
   logic        start_go;
   logic [15:0] acq_cyc;
   logic [15:0] sec_fire;
   logic        conv_end;
   logic        prim_we;
   logic [6:0]  prim_waddr;
   logic [15:0] prim_wdata;
   logic        sec_we;
   logic [6:0]  sec_waddr;
   logic [15:0] sec_wdata;
   logic [4:0]  res_idx;

   // ----------------------------------------
   // link slave
   // ----------------------------------------
   function automatic logic [15:0] reg_read(input logic [6:0] a);
      logic [15:0] d;
      d = 16'h0000;
      if (a == cms_pkg::ADDR_CTRL2) begin
         d = {14'h0000, acq_sel_reg};
      end else if (a == cms_pkg::ADDR_CTRL3) begin
         d[cms_pkg::DELAY_BIT] = delay_en_reg;
      end else if (a == cms_pkg::ADDR_STATUS) begin
         d[0] = busy;
      end else if (!a[6]) begin
         d = mem[a[5:0]];
      end
      return d;
   endfunction

   assign sclk_rise = spi.sclk & ~sclk_q;
   assign sclk_fall = ~spi.sclk & sclk_q;
   assign frame_end = spi.cs_n & ~cs_q;
   assign wr_frame  = frame_end && (bit_cnt_reg == 5'(cms_pkg::FRAME_BITS)) && rx_reg[23];
   assign spi.miso  = miso_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sclk_q <= spi.sclk;
         cs_q   <= spi.cs_n;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_reg <= 5'h00;
         rx_reg      <= 24'h00_0000;
         tx_reg      <= 16'h0000;
         miso_reg    <= 1'b0;
      end else if (spi.cs_n) begin
         bit_cnt_reg <= frame_end ? bit_cnt_reg : 5'h00;
         miso_reg    <= 1'b0;
      end else if (sclk_rise) begin
         rx_reg      <= {rx_reg[22:0], spi.mosi};
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
         if (bit_cnt_reg == 5'(cms_pkg::ADDR_PHASE - 1)) begin
            tx_reg <= reg_read({rx_reg[5:0], spi.mosi});
         end
      end else if (sclk_fall && bit_cnt_reg >= 5'(cms_pkg::ADDR_PHASE)) begin
         miso_reg <= tx_reg[15];
         tx_reg   <= {tx_reg[14:0], 1'b0};
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acq_sel_reg  <= cms_pkg::ACQ_RESET;
         delay_en_reg <= 1'b0;
      end else if (wr_frame && rx_reg[22:16] == cms_pkg::ADDR_CTRL2) begin
         acq_sel_reg <= rx_reg[1:0];
      end else if (wr_frame && rx_reg[22:16] == cms_pkg::ADDR_CTRL3) begin
         delay_en_reg <= rx_reg[cms_pkg::DELAY_BIT];
      end
   end

   assign start_go = wr_frame && rx_reg[22:16] == cms_pkg::ADDR_FUNC_CTRL
                     && rx_reg[cms_pkg::START_BIT];

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   assign acq_cyc  = 16'(cms_pkg::ACQ_BASE_CYC) << acq_sel_reg;
   assign sec_fire = delay_en_reg ? 16'(CONV_CYC - 1 - DELAY_CYC)
                                  : 16'(CONV_CYC - 1);
   assign conv_end = (state_reg == S_CONV) && (cnt_reg == 16'h0000);
   assign busy     = (state_reg != S_IDLE);

   assign prim_chan   = slot_reg;
   assign sec_chan    = slot_reg;
   assign prim_sample = (state_reg == S_CONV) && (cnt_reg == 16'(CONV_CYC - 1));
   assign sec_sample  = (state_reg == S_CONV) && (cnt_reg == sec_fire)
                        && (slot_reg <= LAST_SEC);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_IDLE;
         cnt_reg   <= 16'h0000;
         slot_reg  <= 5'h00;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               if (start_go) begin
                  state_reg <= S_START;
                  cnt_reg   <= 16'(START_CYC - 1);
               end
            end
            S_START: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  state_reg <= S_ACQ;
                  slot_reg  <= 5'h00;
                  cnt_reg   <= acq_cyc - 16'h0001;
               end
            end
            S_ACQ: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  state_reg <= S_CONV;
                  cnt_reg   <= 16'(CONV_CYC - 1);
               end
            end
            S_CONV: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000 && slot_reg == LAST_SLOT) begin
                  state_reg <= S_TEMP;
                  cnt_reg   <= 16'(TEMP_CYC - 1);
               end else if (cnt_reg == 16'h0000) begin
                  state_reg <= S_ACQ;
                  slot_reg  <= slot_reg + 5'h01;
                  cnt_reg   <= acq_cyc - 16'h0001;
               end
            end
            S_TEMP: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // result capture
   // ----------------------------------------
   always_comb begin
      res_idx    = (slot_reg <= 5'd8) ? 5'd8 - slot_reg : slot_reg - 5'd1;
      prim_we    = (conv_end && slot_reg != 5'h00) || (state_reg == S_TEMP
                   && cnt_reg == 16'h0000);
      prim_waddr = cms_pkg::prim_addr(res_idx);
      prim_wdata = {2'h0, prim_code};
      if (state_reg == S_TEMP) begin
         prim_waddr = cms_pkg::ADDR_TEMP;
         prim_wdata = {{2{temp_code[13]}}, temp_code};
      end else if (res_idx < 5'd8 && res_idx >= {1'b0, cells_fitted}) begin
         prim_wdata = 16'h0000;
      end
      sec_we    = conv_end && slot_reg != 5'h00 && slot_reg <= LAST_SEC;
      sec_waddr = cms_pkg::sec_addr(res_idx[3:0]);
      sec_wdata = {6'h00, ~sec_code};
      if (res_idx < 5'd8 && res_idx >= {1'b0, cells_fitted}) begin
         sec_wdata = 16'h0000;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < cms_pkg::MEM_DEPTH; i++) begin
            mem[i] <= 16'h0000;
         end
      end else begin
         if (prim_we) begin
            mem[prim_waddr[5:0]] <= prim_wdata;
         end
         if (sec_we) begin
            mem[sec_waddr[5:0]] <= sec_wdata;
         end
      end
   end
endmodule

// ===== design/cms_host.sv
// cms_host: host end, APB command registers and link master
// assumes an APB master on the system clock; SCLK_DIV of at least 3
`timescale 1ns/1ps
module cms_host #(
   parameter int SCLK_DIV = 4
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   cms_spi_if.host          spi
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW  = 3'b001,
      H_HIGH = 3'b010,
      H_GAP  = 3'b011
   } cms_hst_t;

   localparam int NUM_RES = cms_pkg::NUM_PRIM + cms_pkg::NUM_SEC;

   cms_hst_t         st_reg;
   cms_pkg::cms_op_t op_reg;
   logic [7:0]       div_reg;
   logic [4:0]       bits_reg;
   logic [4:0]       fidx_reg;
   logic [4:0]       nfr_reg;
   logic [23:0]      tx_reg;
   logic [23:0]      rx_reg;
   logic             sclk_reg;
   logic             cs_n_reg;
   logic [3:0]       cfg_reg;
   logic [5:0]       fault_reg;
   logic [31:0]      prdata_reg;
   logic [15:0]      res [0:NUM_RES-1];
   logic             tick;
   logic             apb_wr;
   logic             mapped;
   logic [7:0]       ridx;
   logic [5:0]       fault_now;

   function automatic logic [23:0] frame_of(input cms_pkg::cms_op_t op,
                                             input logic [4:0] i);
      logic [23:0] f;
      f = {1'b0, cms_pkg::sec_addr(4'(i - 5'd18)), 16'h0000};
      if (op == cms_pkg::OP_CFG && i == 5'h00) begin
         f = {1'b1, cms_pkg::ADDR_CTRL2, 14'h0000, cfg_reg[1:0]};
      end else if (op == cms_pkg::OP_CFG) begin
         f = {1'b1, cms_pkg::ADDR_CTRL3, 16'(cfg_reg[2]) << cms_pkg::DELAY_BIT};
      end else if (op == cms_pkg::OP_START) begin
         f = {1'b1, cms_pkg::ADDR_FUNC_CTRL, 16'h0001};
      end else if (i < 5'(cms_pkg::NUM_PRIM)) begin
         f = {1'b0, cms_pkg::prim_addr(i), 16'h0000};
      end
      return f;
   endfunction

   function automatic int mv(input logic [15:0] c, input logic sec);
      if (sec) begin
         return (int'(c[9:0] ^ 10'h3FF) * cms_pkg::FULL_SCALE_MV) >>> cms_pkg::SEC_BITS;
      end
      return (int'(c[13:0]) * cms_pkg::FULL_SCALE_MV) >>> cms_pkg::PRIM_BITS;
   endfunction

   function automatic logic out_of(input int v, input int lo, input int hi);
      return (v < lo) || (v > hi);
   endfunction

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign pready  = psel & penable;
   assign apb_wr  = psel & penable & pwrite;
   assign ridx    = (paddr - cms_pkg::HOST_RES_BASE) >> 2;
   assign mapped  = paddr == cms_pkg::HOST_CMD || paddr == cms_pkg::HOST_CFG
                    || paddr == cms_pkg::HOST_STATUS || (paddr >= cms_pkg::HOST_RES_BASE
                    && ridx < 8'(NUM_RES) && paddr[1:0] == 2'h0);
   assign pslverr = pready & ~mapped;
   assign prdata  = prdata_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_reg <= 32'h0000_0000;
         if (paddr == cms_pkg::HOST_CFG) begin
            prdata_reg <= {28'h000_0000, cfg_reg};
         end else if (paddr == cms_pkg::HOST_STATUS) begin
            prdata_reg <= {25'h000_0000, fault_reg, st_reg != H_IDLE};
         end else if (mapped && paddr >= cms_pkg::HOST_RES_BASE) begin
            prdata_reg <= {16'h0000, res[ridx[4:0]]};
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg_reg <= 4'h0;
      end else if (apb_wr && paddr == cms_pkg::HOST_CFG) begin
         cfg_reg <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // internal check windows
   // ----------------------------------------
   always_comb begin
      fault_now[0] = out_of(mv(res[9], 1'b0), cms_pkg::REF2_MIN, cms_pkg::REF2_MAX);
      fault_now[1] = out_of(mv(res[10], 1'b0), cms_pkg::REG_MIN, cms_pkg::REG_MAX);
      fault_now[2] = out_of(mv(res[15], 1'b0), cms_pkg::BUF_MIN, cms_pkg::BUF_MAX);
      fault_now[3] = out_of(mv(res[16], 1'b0), cms_pkg::REG_MIN, cms_pkg::REG_MAX);
      fault_now[4] = cfg_reg[3] && out_of(mv(res[26], 1'b1), cms_pkg::REF1_MIN,
                                          cms_pkg::REF1_MAX);
      fault_now[5] = cfg_reg[3] && out_of(mv((st_reg == H_GAP) ? rx_reg[15:0] : res[27],
                                             1'b1), cms_pkg::REGS_MIN, cms_pkg::REGS_MAX);
   end

   // ----------------------------------------
   // link master
   // ----------------------------------------
   assign tick     = (div_reg == 8'h00);
   assign spi.sclk = sclk_reg;
   assign spi.cs_n = cs_n_reg;
   assign spi.mosi = tx_reg[23];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_reg    <= H_IDLE;
         op_reg    <= cms_pkg::OP_CFG;
         div_reg   <= 8'h00;
         bits_reg  <= 5'h00;
         fidx_reg  <= 5'h00;
         nfr_reg   <= 5'h00;
         tx_reg    <= 24'h00_0000;
         rx_reg    <= 24'h00_0000;
         sclk_reg  <= 1'b0;
         cs_n_reg  <= 1'b1;
         fault_reg <= 6'h00;
      end else begin
         div_reg <= tick ? 8'(SCLK_DIV - 1) : div_reg - 8'h01;
         unique case (st_reg)
            H_IDLE: begin
               if (apb_wr && paddr == cms_pkg::HOST_CMD && pwdata[2:0] != 3'h0) begin
                  op_reg   <= pwdata[0] ? cms_pkg::OP_CFG :
                              pwdata[1] ? cms_pkg::OP_START : cms_pkg::OP_READ;
                  nfr_reg  <= pwdata[0] ? 5'd2 : pwdata[1] ? 5'd1 :
                              cfg_reg[3] ? 5'(NUM_RES) : 5'(cms_pkg::NUM_PRIM);
                  tx_reg   <= frame_of(pwdata[0] ? cms_pkg::OP_CFG : pwdata[1] ?
                              cms_pkg::OP_START : cms_pkg::OP_READ, 5'h00);
                  fault_reg <= (pwdata[2:0] == 3'h4) ? 6'h00 : fault_reg;
                  fidx_reg <= 5'h00;
                  bits_reg <= 5'h00;
                  cs_n_reg <= 1'b0;
                  div_reg  <= 8'(SCLK_DIV - 1);
                  st_reg   <= H_LOW;
               end
            end
            H_LOW: begin
               if (tick) begin
                  sclk_reg <= 1'b1;
                  rx_reg   <= {rx_reg[22:0], spi.miso};
                  bits_reg <= bits_reg + 5'h01;
                  st_reg   <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tick && bits_reg == 5'(cms_pkg::FRAME_BITS)) begin
                  sclk_reg <= 1'b0;
                  cs_n_reg <= 1'b1;
                  st_reg   <= H_GAP;
               end else if (tick) begin
                  sclk_reg <= 1'b0;
                  tx_reg   <= {tx_reg[22:0], 1'b0};
                  st_reg   <= H_LOW;
               end
            end
            H_GAP: begin
               if (tick && fidx_reg == nfr_reg - 5'h01) begin
                  st_reg    <= H_IDLE;
                  fault_reg <= (op_reg == cms_pkg::OP_READ) ? fault_reg | fault_now
                                                           : fault_reg;
               end else if (tick) begin
                  fidx_reg <= fidx_reg + 5'h01;
                  tx_reg   <= frame_of(op_reg, fidx_reg + 5'h01);
                  bits_reg <= 5'h00;
                  cs_n_reg <= 1'b0;
                  st_reg   <= H_LOW;
               end
            end
            default: begin
               st_reg <= H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_RES; i++) begin
            res[i] <= 16'h0000;
         end
      end else if (st_reg == H_GAP && tick && op_reg == cms_pkg::OP_READ) begin
         res[fidx_reg] <= rx_reg[15:0];
      end
   end
endmodule

// ===== verification/cms_link_monitor.sv
// cms_link_monitor: wire checks on the four-wire link
// assumes host and device share the system clock, SCLK_DIV of 4
`timescale 1ns/1ps
module cms_link_monitor (
   input wire logic clock,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso
);
   // ----------------------------------------
   // rising serial clock count in a frame
   // ----------------------------------------
   logic       sclk_q;
   logic [5:0] rises;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         rises  <= 6'h00;
      end else begin
         sclk_q <= sclk;
         rises  <= cs_n ? 6'h00 : rises + {5'h00, sclk & ~sclk_q};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   miso_idle_a: assert property (cs_n && $past(cs_n) |-> !miso)
      else $error("miso driven outside frame");
   sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("sclk active outside frame");
   frame_open_a: assert property ($fell(cs_n) |-> !sclk)
      else $error("frame opened with sclk high");
   sclk_high_a: assert property ($rose(sclk) |=> sclk [*3])
      else $error("sclk high phase too short");
   mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi moved while sclk high");
   miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso))
      else $error("miso moved while sclk high");
   frame_len_a: assert property ($rose(cs_n) |-> rises == 6'h18)
      else $error("frame not 24 bits");
   frame_time_a: assert property ($fell(cs_n) |-> ##[150:250] $rose(cs_n))
      else $error("frame length out of bound");
   frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*3])
      else $error("gap between frames too short");
endmodule

// ===== verification/tb.sv
// tb: host and device ends joined over the link, driven over apb
// assumes shortened device timing set at the instance below
`timescale 1ns/1ps
module tb;
   // ----------------------------------------
   // ends, link and checker
   // ----------------------------------------
   logic        clock, pready, pslverr, busy, prim_sample, sec_sample, se;
   logic        rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [4:0]  prim_chan, sec_chan;
   logic [3:0]  cells = 4'h5;
   logic [13:0] pcode = 14'h2000, tcode = 14'h3F00;
   logic [9:0]  scode = 10'h334;
   int          num_errors, total_checks, cyc;
   cms_spi_if spi ();
   cms_host cms_host_i (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .spi(spi));
   cms_dev #(.START_CYC(4), .CONV_CYC(4), .DELAY_CYC(1), .TEMP_CYC(8)) cms_dev_i (
      .clock(clock), .rstn(rstn), .spi(spi), .cells_fitted(cells), .prim_code(pcode),
      .sec_code(scode), .temp_code(tcode), .prim_chan(prim_chan),
      .prim_sample(prim_sample), .sec_chan(sec_chan), .sec_sample(sec_sample), .busy(busy));
   cms_link_monitor cms_link_monitor_i (.clock(clock), .rstn(rstn), .sclk(spi.sclk),
      .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("errors=%0d checks=%0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (!pready) @(posedge clock);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic link_idle;
      int q = 0;
      while (q < 40) begin
         @(posedge clock);
         q = spi.cs_n ? q + 1 : 0;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_seq(input int sel, input logic dly);
      int n = 0, np = 0, ns = 0, last = 0;
      apb(1'b1, 8'h04, {28'h000_0000, 1'b1, dly, sel[1:0]});
      apb(1'b1, 8'h00, 32'h0000_0001);
      link_idle();
      apb(1'b1, 8'h00, 32'h0000_0002);
      while (!busy && n < 2000) begin
         @(posedge clock);
         n++;
      end
      last = n;
      while (busy && n < 20000) begin
         @(posedge clock);
         n++;
         if (prim_sample) begin
            chk(n - last, (50 << sel) + 4);
            chk(prim_chan, np);
            last = n;
            np++;
         end
         if (sec_sample) begin
            chk(n - last, dly);
            ns++;
         end
      end
      chk(n - last, 12);
      chk(np, 18);
      chk(ns, 11);
   endtask
   task automatic t_read;
      logic [31:0] e;
      apb(1'b1, 8'h00, 32'h0000_0004);
      link_idle();
      for (int i = 0; i < 28; i++) begin
         apb(1'b0, 8'h40 + 8'(4 * i), 32'h0000_0000);
         if (i == 17) e = 32'h0000_FF00;
         else if (i < 18) e = (i > 7 || i < 5) ? 32'h0000_2000 : 32'h0000_0000;
         else e = (i > 25 || i < 23) ? 32'h0000_00CB : 32'h0000_0000;
         chk(rd, e);
      end
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(rd, 32'h0000_0034);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk({rd[30:0], se}, 32'h0000_0001);
      for (int s = 0; s < 4; s++) t_seq(s, s[0]);
      t_read();
      wrap_up();
   end
endmodule
